// file: hw/civ_cpu_interrupt_vectoring.sv
// interrupt arbitration, vectoring and global enable control for an 8-bit core
// assumes core strobes are on ref_clk, peripheral events are synchronous pulses
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module civ_cpu_interrupt_vectoring #(
	parameter int NSRC = civ_pkg::NUM_SRC
) (
	input  wire logic                  ref_clk,
	input  wire logic                  sys_rst,
	input  wire logic                  clkEn,
	input  wire civ_pkg::civ_bus_req_t busReq,
	output logic [7:0]                 busRdata,
	input  wire logic [NSRC-1:0]       srcEvent,
	input  wire logic [NSRC-1:0]       srcLevelCond,
	input  wire civ_pkg::civ_core_t    core,
	input  wire logic                  reset_vector_fuse,
	input  wire logic                  app_section_lock,
	input  wire logic                  boot_section_lock,
	output civ_pkg::civ_fetch_t        fetch,
	output logic                       resetVecValid,
	output logic [15:0]                resetVecAddr
);

	// ****************************************************************
	// parameter check
	// ****************************************************************
	initial begin
		if (NSRC != 8) begin
			$error("civ: NSRC must be 8 to fit the 8-bit registers");
		end
	end

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		civ_pkg::civ_state_t st;
		logic [2:0]          cnt;
		logic [7:0]          core_status_reg;
		logic [7:0]          core_control_reg;
		logic [7:0]          enable;
		logic [7:0]          flag;
		logic [7:0]          levelType;
		logic [15:0]         bootStart;
		logic                holdOne;
		logic [2:0]          winIdx;
		logic [7:0]          rdata;
		logic                rstVecPend;
		logic [2:0]          strapA;
		logic [2:0]          strapB;
		logic [2:0]          strapC;
		logic [2:0]          strapOk;
	} civ_reg_t;

	civ_reg_t q;
	civ_reg_t d;

	logic [7:0]  pendReq;
	logic        anyReq;
	logic [2:0]  winIdx;
	logic        protectBlock;
	logic        gieEff;
	logic        takeNow;
	logic [15:0] vecBase;
	logic [2:0]  strapPin;
	logic [2:0]  strapNext;

	// ****************************************************************
	// request gating and arbitration
	// ****************************************************************
	// boot protection: pc in boot section with boot lock, or in app section with app lock
	assign protectBlock = (q.strapOk[2] && (core.pc >= q.bootStart))
		|| (q.strapOk[1] && (core.pc < q.bootStart));
	// a clear on this cycle wins over the stored enable and a set, but not over a status write
	assign gieEff = q.core_status_reg[civ_pkg::GIE_BIT] && !core.clearGie;

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_req
			// level sources request straight from the condition, events from the flag
			assign pendReq[gi] = q.enable[gi]
				&& (q.levelType[gi] ? srcLevelCond[gi] : q.flag[gi]);
		end
	endgenerate

	always_comb begin
		winIdx = 3'h0;
		anyReq = 1'b0;
		for (int i = 7; i >= 0; i--) begin
			if (pendReq[i]) begin
				winIdx = 3'(i);
				anyReq = 1'b1;
			end
		end
	end

	assign takeNow = (q.st == civ_pkg::ST_RUN) && core.boundary && anyReq && gieEff
		&& !protectBlock && !q.holdOne && !core.setGie && !core.retInstr;

	assign vecBase = q.core_control_reg[civ_pkg::CTRL_VTS_BIT] ? q.bootStart : 16'h0000;

	// ****************************************************************
	// strap synchronisers
	// ****************************************************************
	// three stages per strap; a change counts once the second and third agree
	// stages keep running in reset so the straps are settled at release
	assign strapPin = {boot_section_lock, app_section_lock, reset_vector_fuse};

	generate
		for (gi = 0; gi < 3; gi++) begin : g_strap
			assign strapNext[gi] = (q.strapB[gi] == q.strapC[gi]) ? q.strapB[gi]
				: q.strapOk[gi];
		end
	endgenerate

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		d = q;
		d.rstVecPend = 1'b0;
		d.strapA = strapPin;
		d.strapB = q.strapA;
		d.strapC = q.strapB;
		d.strapOk = strapNext;
		// events always latch, whatever the enables
		d.flag = q.flag | (srcEvent & ~q.levelType);
		if (core.boundary && q.st == civ_pkg::ST_RUN) begin
			d.holdOne = 1'b0;
		end
		if (core.setGie) begin
			d.core_status_reg[civ_pkg::GIE_BIT] = 1'b1;
			d.holdOne = 1'b1;
		end
		if (core.clearGie) begin
			d.core_status_reg[civ_pkg::GIE_BIT] = 1'b0;
		end
		if (busReq.writeEn) begin
			case (busReq.addr)
				civ_pkg::OFS_STATUS: d.core_status_reg = busReq.wdata;
				civ_pkg::OFS_CTRL:   d.core_control_reg = busReq.wdata;
				civ_pkg::OFS_ENABLE: d.enable = busReq.wdata;
				civ_pkg::OFS_FLAG:   d.flag = (q.flag & ~busReq.wdata)
					| (srcEvent & ~q.levelType);
				civ_pkg::OFS_LEVEL:  d.levelType = busReq.wdata;
				civ_pkg::OFS_BOOTLO: d.bootStart[7:0] = busReq.wdata;
				civ_pkg::OFS_BOOTHI: d.bootStart[15:8] = busReq.wdata;
				default: begin
				end
			endcase
		end
		d.rdata = 8'h00;
		if (busReq.readEn) begin
			case (busReq.addr)
				civ_pkg::OFS_STATUS: d.rdata = q.core_status_reg;
				civ_pkg::OFS_CTRL:   d.rdata = q.core_control_reg;
				civ_pkg::OFS_ENABLE: d.rdata = q.enable;
				civ_pkg::OFS_FLAG:   d.rdata = q.flag;
				civ_pkg::OFS_LEVEL:  d.rdata = q.levelType;
				civ_pkg::OFS_VECTOR: d.rdata = {4'h0, anyReq, winIdx};
				civ_pkg::OFS_BOOTLO: d.rdata = q.bootStart[7:0];
				civ_pkg::OFS_BOOTHI: d.rdata = q.bootStart[15:8];
				default:             d.rdata = 8'h00;
			endcase
		end
		case (q.st)
			civ_pkg::ST_RUN: begin
				if (takeNow) begin
					d.st = civ_pkg::ST_ENTRY;
					d.cnt = 3'(civ_pkg::ENTRY_CYC - 1);
					d.winIdx = winIdx;
					d.core_status_reg[civ_pkg::GIE_BIT] = 1'b0;
					if (!q.levelType[winIdx]) begin
						d.flag[winIdx] = srcEvent[winIdx];
					end
				end else if (core.retInstr && core.boundary) begin
					d.st = civ_pkg::ST_RETURN;
					d.cnt = 3'(civ_pkg::RETURN_CYC - 1);
				end
			end
			civ_pkg::ST_ENTRY: begin
				d.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h0) begin
					d.st = civ_pkg::ST_RUN;
				end
			end
			civ_pkg::ST_RETURN: begin
				d.cnt = q.cnt - 3'h1;
				if (q.cnt == 3'h0) begin
					d.st = civ_pkg::ST_RUN;
					d.core_status_reg[civ_pkg::GIE_BIT] = 1'b1;
					d.holdOne = 1'b1;
				end
			end
			default: d.st = civ_pkg::ST_RUN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			q.st               <= civ_pkg::ST_RUN;
			q.cnt              <= 3'h0;
			q.core_status_reg  <= civ_pkg::STATUS_RST;
			q.core_control_reg <= civ_pkg::CTRL_RST;
			q.enable           <= civ_pkg::ENABLE_RST;
			q.flag             <= civ_pkg::FLAG_RST;
			q.levelType        <= 8'h00;
			q.bootStart        <= civ_pkg::BOOT_START_RST;
			q.holdOne          <= 1'b0;
			q.winIdx           <= 3'h0;
			q.rdata            <= 8'h00;
			q.rstVecPend       <= 1'b1;
			q.strapA           <= d.strapA;
			q.strapB           <= d.strapB;
			q.strapC           <= d.strapC;
			q.strapOk          <= d.strapOk;
		end else if (clkEn) begin
			q <= d;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign busRdata       = q.rdata;
	assign fetch.take     = takeNow;
	// entry k sits at base + (k+1) * stride; reset is entry zero
	assign fetch.vecAddr  = vecBase + 16'({13'h0, q.winIdx} + 16'h1) * civ_pkg::VEC_STRIDE;
	assign fetch.vecIdx   = q.winIdx;
	assign fetch.pushPc   = (q.st == civ_pkg::ST_ENTRY);
	assign fetch.popPc    = (q.st == civ_pkg::ST_RETURN);
	assign fetch.spInc    = (q.st == civ_pkg::ST_RETURN) && (q.cnt == 3'h0);
	assign fetch.busy     = (q.st != civ_pkg::ST_RUN);
	assign resetVecValid  = q.rstVecPend;
	assign resetVecAddr   = q.strapOk[0] ? q.bootStart : civ_pkg::RESET_VEC_APP;

	// ****************************************************************
	// checks
	// ****************************************************************
	a_take_clears_gie: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(takeNow && clkEn) |=> !q.core_status_reg[civ_pkg::GIE_BIT])
		else $error("global enable not cleared on entry");
	a_no_take_cleared: assert property (@(posedge ref_clk) disable iff (sys_rst)
		core.clearGie |-> !takeNow)
		else $error("interrupt taken despite clear");
	a_take_needs_en: assert property (@(posedge ref_clk) disable iff (sys_rst)
		takeNow |-> (q.enable[winIdx] && q.core_status_reg[civ_pkg::GIE_BIT]))
		else $error("interrupt taken while disabled");
	sequence s_entry;
		(fetch.pushPc && clkEn) [*5];
	endsequence
	a_entry_length: assert property (@(posedge ref_clk) disable iff (sys_rst || !clkEn)
		(takeNow) |=> s_entry ##1 !fetch.pushPc)
		else $error("entry not five cycles");
	a_return_sets_gie: assert property (@(posedge ref_clk) disable iff (sys_rst || !clkEn)
		(q.st == civ_pkg::ST_RUN && core.retInstr && core.boundary && !takeNow)
		|-> ##6 q.core_status_reg[civ_pkg::GIE_BIT])
		else $error("return did not set global enable");
	a_return_holds_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
		($fell(fetch.popPc)) |-> !takeNow)
		else $error("interrupt right after return");
	a_sei_holds_one: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(core.setGie && clkEn) |=> !takeNow)
		else $error("interrupt right after set enable");
	a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clkEn && srcEvent[0] && !q.levelType[0]) |=> q.flag[0])
		else $error("event lost");
	a_priority_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(takeNow && pendReq[0]) |-> (winIdx == 3'h0))
		else $error("source zero not first");

	sequence s_return;
		(fetch.popPc && clkEn) [*5];
	endsequence

	a_return_length: assert property (@(posedge ref_clk) disable iff (sys_rst || !clkEn)
		(q.st == civ_pkg::ST_RUN && core.retInstr && core.boundary) |=> s_return ##1 !fetch.popPc)
		else $error("return not five cycles");

	a_spinc_last: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(fetch.spInc && clkEn) |-> fetch.popPc ##1 !fetch.popPc)
		else $error("stack step not in last return cycle");

	a_event_hw_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(takeNow && clkEn && !q.levelType[winIdx] && !srcEvent[winIdx]) |=> !q.flag[q.winIdx])
		else $error("flag not cleared on vectoring");

	a_write_one_clr: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clkEn && busReq.writeEn && busReq.addr == civ_pkg::OFS_FLAG && busReq.wdata[3]
		&& !srcEvent[3]) |=> !q.flag[3])
		else $error("write one did not clear flag");

	a_write_zero_keep: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clkEn && busReq.writeEn && busReq.addr == civ_pkg::OFS_FLAG && !busReq.wdata[3]
		&& q.flag[3] && !takeNow) |=> q.flag[3])
		else $error("write zero changed flag");

	a_level_gone: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(q.levelType[1] && !srcLevelCond[1]) |-> !pendReq[1])
		else $error("level source requests without condition");

	a_level_stands: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(q.levelType[1] && q.enable[1] && srcLevelCond[1]) |-> pendReq[1])
		else $error("level source not requesting");

	a_busy_no_take: assert property (@(posedge ref_clk) disable iff (sys_rst)
		fetch.busy |-> !takeNow)
		else $error("interrupt taken during entry or return");

	a_protect_blocks: assert property (@(posedge ref_clk) disable iff (sys_rst)
		protectBlock |-> !takeNow)
		else $error("interrupt taken in protected code");

	a_ret_no_take: assert property (@(posedge ref_clk) disable iff (sys_rst)
		core.retInstr |-> !takeNow)
		else $error("interrupt taken on return");

	a_rdata_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clkEn && !busReq.readEn) |=> (busRdata == 8'h00))
		else $error("read data outside read cycle");

	a_reset_clears: assert property (@(posedge ref_clk)
		sys_rst |=> (q.flag == civ_pkg::FLAG_RST && q.core_control_reg == civ_pkg::CTRL_RST
		&& !q.core_status_reg[civ_pkg::GIE_BIT]))
		else $error("state not cleared by reset");

	a_gie_write: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(clkEn && busReq.writeEn && busReq.addr == civ_pkg::OFS_STATUS
		&& q.st == civ_pkg::ST_RUN && !takeNow)
		|=> (q.core_status_reg[civ_pkg::GIE_BIT] == $past(busReq.wdata[civ_pkg::GIE_BIT])))
		else $error("global enable not at its bit");

	a_vec_not_reset: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(q.st == civ_pkg::ST_ENTRY) |-> (fetch.vecAddr != vecBase))
		else $error("interrupt vectored to reset entry");

	a_sei_sets_gie: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(core.setGie && clkEn && !core.clearGie
		&& !(busReq.writeEn && busReq.addr == civ_pkg::OFS_STATUS))
		|=> q.core_status_reg[civ_pkg::GIE_BIT])
		else $error("set enable ignored");

	a_cli_clears_gie: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(core.clearGie && clkEn && q.st != civ_pkg::ST_RETURN
		&& !(busReq.writeEn && busReq.addr == civ_pkg::OFS_STATUS))
		|=> !q.core_status_reg[civ_pkg::GIE_BIT])
		else $error("clear enable ignored");

	a_winner_pending: assert property (@(posedge ref_clk) disable iff (sys_rst)
		anyReq |-> pendReq[winIdx])
		else $error("winner not pending");

	a_winner_lowest: assert property (@(posedge ref_clk) disable iff (sys_rst)
		anyReq |-> ((pendReq & ((8'h01 << winIdx) - 8'h01)) == 8'h00))
		else $error("lower pending source passed over");

endmodule : civ_cpu_interrupt_vectoring

// file: hw/civ_pkg.sv
// package for the interrupt vectoring block
// assumes one cpu clock and a core that samples requests at instruction boundaries
package civ_pkg;

	// ****************************************************************
	// sizes and timing
	// ****************************************************************
	localparam int NUM_SRC         = 8;
	localparam int PC_W            = 16;
	localparam int ENTRY_CYC       = 5;
	localparam int RETURN_CYC      = 5;
	localparam int GIE_BIT         = 7;
	localparam int SP_RET_INC      = 2;

	// ****************************************************************
	// register offsets on the plain port
	// ****************************************************************
	localparam logic [3:0] OFS_STATUS  = 4'h0;
	localparam logic [3:0] OFS_CTRL    = 4'h1;
	localparam logic [3:0] OFS_ENABLE  = 4'h2;
	localparam logic [3:0] OFS_FLAG    = 4'h3;
	localparam logic [3:0] OFS_LEVEL   = 4'h4;
	localparam logic [3:0] OFS_VECTOR  = 4'h5;
	localparam logic [3:0] OFS_BOOTLO  = 4'h6;
	localparam logic [3:0] OFS_BOOTHI  = 4'h7;

	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int          CTRL_VTS_BIT  = 1;
	localparam logic [7:0]  STATUS_RST    = 8'h00;
	localparam logic [7:0]  CTRL_RST      = 8'h00;
	localparam logic [7:0]  ENABLE_RST    = 8'h00;
	localparam logic [7:0]  FLAG_RST      = 8'h00;
	localparam logic [15:0] BOOT_START_RST = 16'hF000;
	localparam logic [15:0] RESET_VEC_APP = 16'h0000;
	localparam logic [15:0] VEC_STRIDE    = 16'h0002;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_ENTRY  = 2'b01,
		ST_RETURN = 2'b10
	} civ_state_t;

	typedef struct packed {
		logic        writeEn;
		logic        readEn;
		logic [3:0]  addr;
		logic [7:0]  wdata;
	} civ_bus_req_t;

	typedef struct packed {
		logic        boundary;
		logic        setGie;
		logic        clearGie;
		logic        retInstr;
		logic [15:0] pc;
	} civ_core_t;

	typedef struct packed {
		logic        take;
		logic [15:0] vecAddr;
		logic [2:0]  vecIdx;
		logic        pushPc;
		logic        popPc;
		logic        spInc;
		logic        busy;
	} civ_fetch_t;

endpackage : civ_pkg

// file: verification/civ_core_model.sv
// partner model: core fetch side facing the interrupt vectoring block
// assumes the bench pulses doSet, doClr and doRet for one cycle, off entry and return
module civ_core_model (
	input  wire logic                ref_clk,
	input  wire logic                sys_rst,
	input  wire civ_pkg::civ_fetch_t fetch,
	input  wire logic                doSet,
	input  wire logic                doClr,
	input  wire logic                doRet,
	output civ_pkg::civ_core_t       core
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] pc_q;

	// a boundary only where no entry or return runs
	assign core = '{!fetch.busy, doSet, doClr, doRet, pc_q};

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pc_q <= 16'h0100;
		end else if (core.boundary) begin
			pc_q <= pc_q + 16'h0001;
		end
	end
endmodule : civ_core_model

// file: verification/civ_cpu_interrupt_vectoring_tb_top.sv
// self-checking bench for the interrupt vectoring block
// assumes the core model drives the core strobes; the bench drives bus, sources and straps
module civ_cpu_interrupt_vectoring_tb_top;
	timeunit 1ns;
	timeprecision 1ps;

	// ********************
	// signals
	// ********************
	logic                  ref_clk      = 1'b0;
	logic                  sys_rst      = 1'b1;
	civ_pkg::civ_bus_req_t busReq       = '0;
	logic [7:0]            busRdata;
	logic [7:0]            srcEvent     = 8'h00;
	logic [7:0]            srcLevelCond = 8'h00;
	civ_pkg::civ_core_t    core;
	civ_pkg::civ_fetch_t   fetch;
	logic                  fuse         = 1'b0;
	logic                  appLock      = 1'b0;
	logic                  bootLock     = 1'b0;
	logic                  doSet        = 1'b0;
	logic                  doClr        = 1'b0;
	logic                  doRet        = 1'b0;
	logic                  resetVecValid;
	logic [15:0]           resetVecAddr;
	int                    nMismatch    = 0;
	int                    checked      = 0;
	int                    np;
	int                    nq;
	int                    ns;

	always #12.5 ref_clk = ~ref_clk;

	civ_cpu_interrupt_vectoring dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clkEn(1'b1),
		.busReq(busReq), .busRdata(busRdata), .srcEvent(srcEvent), .srcLevelCond(srcLevelCond),
		.core(core), .reset_vector_fuse(fuse), .app_section_lock(appLock),
		.boot_section_lock(bootLock), .fetch(fetch), .resetVecValid(resetVecValid),
		.resetVecAddr(resetVecAddr));

	civ_core_model partner (.ref_clk(ref_clk), .sys_rst(sys_rst), .fetch(fetch),
		.doSet(doSet), .doClr(doClr), .doRet(doRet), .core(core));

	// ********************
	// tasks
	// ********************
	task automatic results();
		$display("mismatches %0d, comparisons %0d", nMismatch, checked);
		if (nMismatch == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			nMismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk) busReq <= '{1'b1, 1'b0, a, d};
		@(posedge ref_clk) busReq <= '0;
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge ref_clk) busReq <= '{1'b0, 1'b1, a, 8'h00};
		@(posedge ref_clk) busReq <= '0;
		#1 chk({8'h00, busRdata}, {8'h00, e});
	endtask : rd

	task automatic pulse(input logic [7:0] m);
		@(posedge ref_clk) srcEvent <= m;
		@(posedge ref_clk) srcEvent <= 8'h00;
	endtask : pulse

	task automatic instr(input logic [2:0] m);
		@(posedge ref_clk) {doSet, doClr, doRet} <= m;
		appLock <= 1'b0;
		#1 chk(16'(fetch.take), 16'h0000);
		@(posedge ref_clk) {doSet, doClr, doRet} <= 3'b000;
		#1 chk(16'(fetch.take), 16'h0000);
	endtask : instr

	task automatic noTake(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			#1 chk(16'(fetch.take), 16'h0000);
		end
	endtask : noTake

	task automatic waitTake(input logic [2:0] idx, input logic [15:0] addr);
		int k;
		#1;
		for (k = 0; k < 40 && fetch.take !== 1'b1; k++) begin
			@(posedge ref_clk);
			#1;
		end
		if (k == 40) begin
			nMismatch++;
			results();
		end
		@(posedge ref_clk);
		#1 chk(16'(fetch.vecIdx), 16'(idx));
		chk(fetch.vecAddr, addr);
	endtask : waitTake

	task automatic waitIdle();
		int k;
		np = 0;
		nq = 0;
		ns = 0;
		for (k = 0; k < 40 && fetch.busy !== 1'b0; k++) begin
			np += fetch.pushPc;
			nq += fetch.popPc;
			ns += fetch.spInc;
			@(posedge ref_clk);
			#1;
		end
		if (k == 40) begin
			nMismatch++;
			results();
		end
	endtask : waitIdle

	// ********************
	// sequence
	// ********************
	initial begin
		repeat (9) @(posedge ref_clk);
		#1 chk(16'(resetVecValid), 16'h0001);
		@(posedge ref_clk) sys_rst <= 1'b0;
		rd(civ_pkg::OFS_STATUS, 8'h00);
		rd(civ_pkg::OFS_CTRL, 8'h00);
		rd(civ_pkg::OFS_FLAG, 8'h00);
		rd(civ_pkg::OFS_BOOTHI, 8'hF0);
		rd(4'hF, 8'h00);
		chk(resetVecAddr, 16'h0000);
		$display("test reset done");
		pulse(8'h08);
		rd(civ_pkg::OFS_FLAG, 8'h08);
		wr(civ_pkg::OFS_FLAG, 8'hF7);
		rd(civ_pkg::OFS_FLAG, 8'h08);
		wr(civ_pkg::OFS_FLAG, 8'h08);
		rd(civ_pkg::OFS_FLAG, 8'h00);
		$display("test flags done");
		wr(civ_pkg::OFS_ENABLE, 8'hFF);
		pulse(8'h24);
		noTake(3);
		wr(civ_pkg::OFS_STATUS, 8'h80);
		waitTake(3'h2, 16'h0006);
		waitIdle();
		chk(16'(np), 16'h0005);
		rd(civ_pkg::OFS_STATUS, 8'h00);
		rd(civ_pkg::OFS_FLAG, 8'h20);
		pulse(8'h80);
		wr(civ_pkg::OFS_STATUS, 8'h80);
		waitTake(3'h5, 16'h000C);
		waitIdle();
		instr(3'b001);
		waitIdle();
		chk(16'(nq), 16'h0005);
		chk(16'(ns), 16'h0001);
		chk(16'(fetch.take), 16'h0000);
		waitTake(3'h7, 16'h0010);
		waitIdle();
		$display("test priority done");
		wr(civ_pkg::OFS_CTRL, 8'h02);
		@(posedge ref_clk) appLock <= 1'b1;
		wr(civ_pkg::OFS_ENABLE, 8'h01);
		pulse(8'h01);
		wr(civ_pkg::OFS_STATUS, 8'h80);
		noTake(3);
		instr(3'b010);
		rd(civ_pkg::OFS_STATUS, 8'h00);
		instr(3'b100);
		waitTake(3'h0, 16'hF002);
		waitIdle();
		$display("test enable done");
		wr(civ_pkg::OFS_LEVEL, 8'h02);
		wr(civ_pkg::OFS_ENABLE, 8'h00);
		@(posedge ref_clk) srcLevelCond <= 8'h02;
		@(posedge ref_clk) srcLevelCond <= 8'h00;
		wr(civ_pkg::OFS_ENABLE, 8'h02);
		wr(civ_pkg::OFS_STATUS, 8'h80);
		noTake(3);
		@(posedge ref_clk) srcLevelCond <= 8'h02;
		waitTake(3'h1, 16'hF004);
		@(posedge ref_clk) srcLevelCond <= 8'h00;
		waitIdle();
		@(posedge ref_clk) fuse <= 1'b1;
		repeat (5) @(posedge ref_clk);
		#1 chk(resetVecAddr, 16'hF000);
		$display("test level done");
		results();
	end
endmodule : civ_cpu_interrupt_vectoring_tb_top
